// ### inc/pce_defines.svh
// register offsets, field positions, reset values and sizes for the pin change block
`ifndef PCE_DEFINES_SVH
`define PCE_DEFINES_SVH

`define PCE_OFF_PORTB_RISE 12'h000
`define PCE_OFF_PORTB_FALL 12'h004
`define PCE_OFF_PORTB_FLAG 12'h008
`define PCE_OFF_PORTC_RISE 12'h00c
`define PCE_OFF_PORTC_FALL 12'h010
`define PCE_OFF_PORTC_FLAG 12'h014
`define PCE_OFF_CTRL 12'h018
`define PCE_OFF_STATUS 12'h01c

`define PCE_PORTB_MASK 8'hf0
`define PCE_PORTC_MASK_SMALL 8'h3f
`define PCE_PORTC_MASK_LARGE 8'hff
`define PCE_REG_RESET 8'h00
`define PCE_CTRL_IRQ_EN_BIT 0
`define PCE_STAT_SUMMARY_BIT 0
`define PCE_STAT_IRQ_BIT 1
`define PCE_SYNC_STAGES 3

`endif

// ### inc/pce_pkg.sv
// types shared by the pin change edge detect block
package pce_pkg;
   typedef struct packed {
      logic [11:0] paddr;
      logic pwrite;
      logic [31:0] pwdata;
      logic psel;
      logic penable;
   } pce_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } pce_apb_rsp_t;

   typedef struct packed {
      logic [7:0] rise;
      logic [7:0] fall;
   } pce_edge_t;
endpackage

// ### hdl/pce_pin_sync.sv
// three-stage synchroniser and edge detector for a group of pins
`timescale 1ns/1ps
module pce_pin_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // asynchronous pins
   input wire logic [WIDTH-1:0] pin_async,
   // one-cycle edge pulses
   output pce_pkg::pce_edge_t edges
);
   import pce_pkg::*;

   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] level_r;

   // s1 feeds only s2; a change counts once s2 and s3 agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= pin_async;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // agreed level; pins held low at reset give no edge on release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_r <= '0;
      end else begin
         level_r <= (s2_r & s3_r) | (level_r & (s2_r | s3_r));
      end
   end

   // compare agreed level with previous one for a one-cycle pulse
   always_comb begin
      edges = '0;
      edges.rise[WIDTH-1:0] = (s2_r & s3_r) & ~level_r;
      edges.fall[WIDTH-1:0] = ~(s2_r | s3_r) & level_r;
   end
endmodule

// ### hdl/pce_flag_bank.sv
// per-pin sticky change flags with hardware set winning over software clear
`timescale 1ns/1ps
module pce_flag_bank #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // implemented bits
   input wire logic [WIDTH-1:0] impl_mask,
   // edge enables and pulses
   input wire logic [WIDTH-1:0] rise_en,
   input wire logic [WIDTH-1:0] fall_en,
   input pce_pkg::pce_edge_t edges,
   // software write
   input wire logic wr_en,
   input wire logic [WIDTH-1:0] wr_data,
   // flag state
   output logic [WIDTH-1:0] flags_r
);
   import pce_pkg::*;

   logic [WIDTH-1:0] hit;
   logic [WIDTH-1:0] flags_nxt;

   // either enabled edge qualifies; both enables catch both edges
   assign hit = impl_mask & ((rise_en & edges.rise[WIDTH-1:0]) |
                             (fall_en & edges.fall[WIDTH-1:0]));

   // software value first, then hardware set on top so no edge is lost
   always_comb begin
      flags_nxt = flags_r;
      if (wr_en) begin
         flags_nxt = wr_data & impl_mask;
      end
      flags_nxt = flags_nxt | hit;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_r <= '0;
      end else begin
         flags_r <= flags_nxt;
      end
   end
endmodule

// ### hdl/pce_top.sv
// pin change edge detect block with apb register slave
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "pce_defines.svh"

module pce_top #(
   parameter bit LARGE_PACKAGE = 1'b1
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input pce_pkg::pce_apb_req_t apb_req,
   output pce_pkg::pce_apb_rsp_t apb_rsp,
   // port pins
   input wire logic [7:0] portb_pin,
   input wire logic [7:0] portc_pin,
   // interrupt and wake
   output logic change_summary_flag,
   output logic change_irq,
   output logic change_wake
);
   import pce_pkg::*;

   localparam logic [7:0] PORTB_MASK = `PCE_PORTB_MASK;
   localparam logic [7:0] PORTC_MASK = LARGE_PACKAGE ? `PCE_PORTC_MASK_LARGE :
                                                       `PCE_PORTC_MASK_SMALL;

   logic [7:0] portb_rise_enable_r;
   logic [7:0] portb_fall_enable_r;
   logic [7:0] portc_rise_enable_r;
   logic [7:0] portc_fall_enable_r;
   logic change_irq_enable_r;
   logic [7:0] portb_change_flags;
   logic [7:0] portc_change_flags;
   logic [31:0] prdata_r;
   logic wr_acc;
   logic rd_acc;
   logic addr_ok;
   logic [31:0] rd_mux;
   logic event_any;
   pce_edge_t portb_edges;
   pce_edge_t portc_edges;

   // zero-wait slave: access phase completes in its first cycle
   assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign rd_acc = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

   // synchronisers for both ports
   pce_pin_sync #(.WIDTH(8)) u_sync_b (
      .pclk(pclk),
      .presetn(presetn),
      .pin_async(portb_pin),
      .edges(portb_edges)
   );

   pce_pin_sync #(.WIDTH(8)) u_sync_c (
      .pclk(pclk),
      .presetn(presetn),
      .pin_async(portc_pin),
      .edges(portc_edges)
   );

   // port b enables; only bits 7..4 exist
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         portb_rise_enable_r <= `PCE_REG_RESET;
         portb_fall_enable_r <= `PCE_REG_RESET;
      end else if (wr_acc) begin
         if (apb_req.paddr == `PCE_OFF_PORTB_RISE) begin
            portb_rise_enable_r <= apb_req.pwdata[7:0] & PORTB_MASK;
         end
         if (apb_req.paddr == `PCE_OFF_PORTB_FALL) begin
            portb_fall_enable_r <= apb_req.pwdata[7:0] & PORTB_MASK;
         end
      end
   end

   // port c enables; top two bits only on the large variant
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         portc_rise_enable_r <= `PCE_REG_RESET;
         portc_fall_enable_r <= `PCE_REG_RESET;
      end else if (wr_acc) begin
         if (apb_req.paddr == `PCE_OFF_PORTC_RISE) begin
            portc_rise_enable_r <= apb_req.pwdata[7:0] & PORTC_MASK;
         end
         if (apb_req.paddr == `PCE_OFF_PORTC_FALL) begin
            portc_fall_enable_r <= apb_req.pwdata[7:0] & PORTC_MASK;
         end
      end
   end

   // global change interrupt enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         change_irq_enable_r <= 1'b0;
      end else if (wr_acc && apb_req.paddr == `PCE_OFF_CTRL) begin
         change_irq_enable_r <= apb_req.pwdata[`PCE_CTRL_IRQ_EN_BIT];
      end
   end

   // flag banks keep detecting regardless of the global enable
   pce_flag_bank #(.WIDTH(8)) u_flags_b (
      .pclk(pclk),
      .presetn(presetn),
      .impl_mask(PORTB_MASK),
      .rise_en(portb_rise_enable_r),
      .fall_en(portb_fall_enable_r),
      .edges(portb_edges),
      .wr_en(wr_acc && apb_req.paddr == `PCE_OFF_PORTB_FLAG),
      .wr_data(apb_req.pwdata[7:0]),
      .flags_r(portb_change_flags)
   );

   pce_flag_bank #(.WIDTH(8)) u_flags_c (
      .pclk(pclk),
      .presetn(presetn),
      .impl_mask(PORTC_MASK),
      .rise_en(portc_rise_enable_r),
      .fall_en(portc_fall_enable_r),
      .edges(portc_edges),
      .wr_en(wr_acc && apb_req.paddr == `PCE_OFF_PORTC_FLAG),
      .wr_data(apb_req.pwdata[7:0]),
      .flags_r(portc_change_flags)
   );

   // summary is pure OR of flags, so it has no write path
   assign change_summary_flag = |{portb_change_flags, portc_change_flags};
   // request gated by global enable only; flags stay live underneath
   assign change_irq = change_summary_flag & change_irq_enable_r;
   // wake follows the request; flags are already registered when it rises
   assign change_wake = change_irq;
   assign event_any = change_irq;

   // read decode; unmapped addresses read zero with an error
   always_comb begin
      rd_mux = 32'h0000_0000;
      addr_ok = 1'b1;
      unique case (apb_req.paddr)
         `PCE_OFF_PORTB_RISE: rd_mux[7:0] = portb_rise_enable_r & PORTB_MASK;
         `PCE_OFF_PORTB_FALL: rd_mux[7:0] = portb_fall_enable_r & PORTB_MASK;
         `PCE_OFF_PORTB_FLAG: rd_mux[7:0] = portb_change_flags & PORTB_MASK;
         `PCE_OFF_PORTC_RISE: rd_mux[7:0] = portc_rise_enable_r & PORTC_MASK;
         `PCE_OFF_PORTC_FALL: rd_mux[7:0] = portc_fall_enable_r & PORTC_MASK;
         `PCE_OFF_PORTC_FLAG: rd_mux[7:0] = portc_change_flags & PORTC_MASK;
         `PCE_OFF_CTRL: rd_mux[`PCE_CTRL_IRQ_EN_BIT] = change_irq_enable_r;
         `PCE_OFF_STATUS: begin
            rd_mux[`PCE_STAT_SUMMARY_BIT] = change_summary_flag;
            rd_mux[`PCE_STAT_IRQ_BIT] = event_any;
         end
         default: addr_ok = 1'b0;
      endcase
   end

   // read data captured in setup so it stands through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (rd_acc) begin
         prdata_r <= rd_mux;
      end
   end

   // response: always ready, error on unmapped address
   always_comb begin
      apb_rsp.prdata = prdata_r;
      apb_rsp.pready = 1'b1;
      apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~addr_ok;
   end
endmodule

// ### bench/pce_top_props.sv
// assertions for the pin change edge detect block, bound to its top
`timescale 1ns/1ps
`include "pce_defines.svh"
module pce_top_props (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input pce_pkg::pce_apb_req_t apb_req,
   input pce_pkg::pce_apb_rsp_t apb_rsp,
   // pins and outputs
   input wire logic [7:0] portb_pin,
   input wire logic [7:0] portc_pin,
   input wire logic change_summary_flag,
   input wire logic change_irq,
   input wire logic change_wake
);
   import pce_pkg::*;
   logic acc, wr, rd;
   logic [7:0] pb_r, pc_r;
   logic [3:0] quiet_r;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign acc = apb_req.psel && apb_req.penable;
   assign wr = acc && apb_req.pwrite;
   assign rd = acc && !apb_req.pwrite;
   // quiet cycles: with no pin motion and no write a flag has no cause to rise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pb_r <= 8'h00;
         pc_r <= 8'h00;
         quiet_r <= 4'h0;
      end else begin
         pb_r <= portb_pin;
         pc_r <= portc_pin;
         if (portb_pin != pb_r || portc_pin != pc_r || wr) begin
            quiet_r <= 4'h0;
         end else if (quiet_r != 4'hf) begin
            quiet_r <= quiet_r + 4'h1;
         end
      end
   end
   wake_irq_a: assert property (change_wake == change_irq)
      else $error("wake differs from irq");
   irq_gate_a: assert property (change_irq |-> change_summary_flag)
      else $error("irq without a flag");
   ctrl_irq_a: assert property (wr && apb_req.paddr == `PCE_OFF_CTRL |=>
      change_irq == ($past(apb_req.pwdata[0]) && change_summary_flag))
      else $error("irq does not follow enable");
   no_cause_a: assert property (quiet_r >= 4'h6 |-> !$rose(change_summary_flag))
      else $error("flag rose without cause");
   flag_fall_a: assert property ($fell(change_summary_flag) |-> $past(wr))
      else $error("flag fell without a write");
   reset_clear_a: assert property ($rose(presetn) |-> !change_summary_flag)
      else $error("flag set after reset");
   unmapped_a: assert property (acc && apb_req.paddr > `PCE_OFF_STATUS |->
      apb_rsp.pslverr && (apb_req.pwrite || apb_rsp.prdata == 32'h0))
      else $error("unmapped access not refused");
   upper_zero_a: assert property (rd |-> apb_rsp.prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   portb_low_a: assert property (rd && apb_req.paddr <= `PCE_OFF_PORTB_FLAG |->
      apb_rsp.prdata[3:0] == 4'h0)
      else $error("port b low bits set");
   cover property ($rose(change_irq));
   cover property (wr && apb_req.paddr == `PCE_OFF_PORTC_FLAG);
   cover property (acc && apb_rsp.pslverr);
endmodule

bind pce_top pce_top_props u_props (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .portb_pin(portb_pin), .portc_pin(portc_pin),
   .change_summary_flag(change_summary_flag), .change_irq(change_irq),
   .change_wake(change_wake));

// ### bench/pce_pins_model.sv
// far-side model of the port pins: drives the levels the bench asks for
`timescale 1ns/1ps
module pce_pins_model (
   // clock
   input wire logic pclk,
   // requested levels
   input wire logic [7:0] b_want,
   input wire logic [7:0] c_want,
   // pins
   output logic [7:0] portb_pin,
   output logic [7:0] portc_pin
);
   initial begin
      portb_pin = 8'h00;
      portc_pin = 8'h00;
   end
   // levels move just after an edge and stand many clocks, so no pulse is too short
   always @(posedge pclk) begin
      portb_pin <= b_want;
      portc_pin <= c_want;
   end
endmodule

// ### bench/pin_change_edge_detect_test.sv
// self-checking bench for the pin change edge detect block
`timescale 1ns/1ps
`include "pce_defines.svh"
module pin_change_edge_detect_test;
   import pce_pkg::*;
   logic pclk, presetn;
   pce_apb_req_t req;
   pce_apb_rsp_t rsp;
   logic [7:0] b_want, c_want, portb_pin, portc_pin;
   logic summary, irq, wake;
   logic [31:0] rdat;
   logic rerr;
   int failures, cmp_count, i;
   pce_pins_model pins (.pclk(pclk), .b_want(b_want), .c_want(c_want),
      .portb_pin(portb_pin), .portc_pin(portc_pin));
   pce_top uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
      .portb_pin(portb_pin), .portc_pin(portc_pin), .change_summary_flag(summary),
      .change_irq(irq), .change_wake(wake));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic give_verdict();
      if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // one apb transfer; the request stands until pready is seen high at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge pclk);
      req <= '{paddr: a, pwrite: w, pwdata: {24'h0, d}, psel: 1'b1, penable: 1'b0};
      @(posedge pclk);
      req.penable <= 1'b1;
      do @(posedge pclk); while (rsp.pready !== 1'b1);
      rdat = rsp.prdata;
      rerr = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic chk(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      cmp_count++;
      if (rdat !== {24'h0, e}) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, rdat, {24'h0, e});
      end
   endtask
   // summary, request and wake pins, looked at mid-cycle where they are settled
   task automatic chk_out(input logic [2:0] e);
      @(negedge pclk);
      cmp_count++;
      if ({summary, irq, wake} !== e) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, {summary, irq, wake}, e);
      end
   endtask
   // new pin levels, then time for the model, three sync stages and the flag
   task automatic pins_to(input logic [7:0] b, input logic [7:0] c);
      @(posedge pclk);
      b_want <= b;
      c_want <= c;
      repeat (8) @(posedge pclk);
   endtask
   initial begin
      req = '0;
      b_want = 8'h00;
      c_want = 8'h00;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 8; i++) chk(12'(i * 4), 8'h00);
      apb(1'b1, `PCE_OFF_PORTB_FALL, 8'hff);
      chk(`PCE_OFF_PORTB_FALL, 8'hf0);
      apb(1'b1, `PCE_OFF_PORTC_RISE, 8'hff);
      chk(`PCE_OFF_PORTC_RISE, 8'hff);
      apb(1'b1, `PCE_OFF_PORTB_RISE, 8'h10);
      apb(1'b1, `PCE_OFF_PORTB_FALL, 8'h20);
      apb(1'b1, `PCE_OFF_PORTC_RISE, 8'h05);
      apb(1'b1, `PCE_OFF_PORTC_FALL, 8'h06);
      pins_to(8'h3f, 8'h03);
      chk(`PCE_OFF_PORTB_FLAG, 8'h10);
      chk(`PCE_OFF_PORTC_FLAG, 8'h01);
      chk(`PCE_OFF_STATUS, 8'h01);
      chk_out(3'b100);
      pins_to(8'h00, 8'h04);
      chk(`PCE_OFF_PORTB_FLAG, 8'h30);
      chk(`PCE_OFF_PORTC_FLAG, 8'h07);
      apb(1'b1, `PCE_OFF_CTRL, 8'h01);
      chk(`PCE_OFF_STATUS, 8'h03);
      chk_out(3'b111);
      apb(1'b1, `PCE_OFF_PORTC_FLAG, 8'h00);
      chk(`PCE_OFF_PORTC_FLAG, 8'h00);
      apb(1'b1, `PCE_OFF_STATUS, 8'h00);
      chk(`PCE_OFF_STATUS, 8'h03);
      apb(1'b1, `PCE_OFF_PORTB_FLAG, 8'h0f);
      chk(`PCE_OFF_STATUS, 8'h00);
      chk_out(3'b000);
      pins_to(8'h00, 8'h00);
      chk(`PCE_OFF_PORTC_FLAG, 8'h04);
      chk(12'h020, 8'h00);
      cmp_count++;
      if (rerr !== 1'b1) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, rerr, 1'b1);
      end
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk(`PCE_OFF_PORTC_FLAG, 8'h00);
      chk(`PCE_OFF_PORTC_FALL, 8'h00);
      give_verdict();
   end
   // cuts a hang short well beyond the 150 or so cycles the tests need
   initial begin
      repeat (3000) @(posedge pclk);
      failures++;
      give_verdict();
   end
endmodule
